// ---- verilog/ticc_pkg.sv ----
// package for the timer input-capture channel block
// assumes a byte-wide register port with 16-bit addresses
package ticc_pkg;
   localparam int NUM_CHAN = 6;
   localparam int CNT_WIDTH = 16;
   localparam int DIV_WIDTH = 6;
   // clock select codes
   localparam logic [2:0] PS_EXT_CLOCK = 3'h7;
   localparam logic [2:0] PS_RESET = 3'h0;
   // timer status and control, counter
   localparam logic [15:0] TIMER_CONTROL_ADDR = 16'h002B;
   localparam logic [15:0] COUNT_HIGH_ADDR = 16'h002C;
   localparam logic [15:0] COUNT_LOW_ADDR = 16'h002D;
   // channel control and value registers, index = channel
   localparam logic [15:0] CHAN_CONTROL_ADDR [NUM_CHAN] =
      '{16'h0030, 16'h0033, 16'h0456, 16'h0459, 16'h045C, 16'h045F};
   localparam logic [15:0] CHAN_VALUE_HIGH_ADDR [NUM_CHAN] =
      '{16'h0031, 16'h0034, 16'h0457, 16'h045A, 16'h045D, 16'h0460};
   localparam logic [15:0] CHAN_VALUE_LOW_ADDR [NUM_CHAN] =
      '{16'h0032, 16'h0035, 16'h0458, 16'h045B, 16'h045E, 16'h0461};
   // interrupt status and mask
   localparam logic [15:0] IRQ_STATUS_ADDR = 16'h0462;
   localparam logic [15:0] IRQ_MASK_ADDR = 16'h0463;
   // channel control field positions
   localparam int CTL_FLAG_BIT = 7;
   localparam int CTL_IE_BIT = 6;
   localparam int CTL_MSB_BIT = 5;
   localparam int CTL_MSA_BIT = 4;
   localparam int CTL_ELSB_BIT = 3;
   localparam int CTL_ELSA_BIT = 2;
   localparam int CTL_TOV_BIT = 1;
   localparam int CTL_MAX_BIT = 0;
   localparam logic [7:0] CHAN_CONTROL_RESET = 8'h00;
   localparam logic [7:0] ODD_CONTROL_MASK = 8'hDF;
   localparam logic [7:0] EVEN_CONTROL_MASK = 8'hFF;
   // interrupt status layout: bits 5..0 captures, bit 6 overflow
   localparam int IRQ_OVF_BIT = 6;
   localparam logic [7:0] IRQ_STATUS_RESET = 8'h00;
   localparam logic [7:0] IRQ_MASK_RESET = 8'h00;
   localparam logic [7:0] IRQ_IMPL_MASK = 8'h7F;
   localparam logic [7:0] READ_UNMAPPED = 8'h00;
   // edge select encodings
   typedef enum logic [1:0] {
      EDGE_OFF = 2'h0,
      EDGE_RISE = 2'h1,
      EDGE_FALL = 2'h2,
      EDGE_ANY = 2'h3
   } ticc_edge_type;
endpackage : ticc_pkg

// ---- verilog/ticc_capture.sv ----
// timer counter, prescaler and six input-capture channels with register port
// assumes pins synchronous-sampled on mclk, one-cycle bus strobes
`timescale 1ns/1ps
`default_nettype none
module ticc_capture #(
   parameter int NUM_CHAN = ticc_pkg::NUM_CHAN,
   parameter int CNT_WIDTH = ticc_pkg::CNT_WIDTH
) (
   input wire logic mclk,
   input wire logic rst,
   input wire logic [15:0] bus_addr,
   input wire logic [7:0] bus_wdata,
   input wire logic bus_wr,
   input wire logic bus_rd,
   output logic [7:0] bus_rdata,
   input wire logic [NUM_CHAN-1:0] chan_pin,
   output logic irq
);
   logic [NUM_CHAN-1:0] pin_meta_ff;
   logic [NUM_CHAN-1:0] pin_sync_ff;
   logic [NUM_CHAN-1:0] pin_prev_ff;
   logic [NUM_CHAN-1:0] rise;
   logic [NUM_CHAN-1:0] fall;
   logic [NUM_CHAN-1:0] cap;
   logic [2:0] ps_ff;
   logic [ticc_pkg::DIV_WIDTH-1:0] div_ff;
   logic [ticc_pkg::DIV_WIDTH-1:0] div_mask;
   logic tick;
   logic [CNT_WIDTH-1:0] count_ff;
   logic ovf;
   logic [7:0] ctrl_ff [NUM_CHAN];
   logic [CNT_WIDTH-1:0] value_ff [NUM_CHAN];
   logic [7:0] irq_status_ff;
   logic [7:0] irq_mask_ff;
   logic [7:0] irq_events;
   logic [7:0] nxt_rdata;
   logic [7:0] bus_rdata_ff;
   logic [NUM_CHAN-1:0] chan_req;
   logic status_rd;

   // pin synchronisers and edge detect
   always_ff @(posedge mclk) begin
      if (rst) begin
         pin_meta_ff <= '0;
         pin_sync_ff <= '0;
         pin_prev_ff <= '0;
      end else begin
         pin_meta_ff <= chan_pin;
         pin_sync_ff <= pin_meta_ff;
         pin_prev_ff <= pin_sync_ff;
      end
   end

   assign rise = pin_sync_ff & ~pin_prev_ff;
   assign fall = ~pin_sync_ff & pin_prev_ff;

   // clock select register
   always_ff @(posedge mclk) begin
      if (rst) begin
         ps_ff <= ticc_pkg::PS_RESET;
      end else if (bus_wr && bus_addr == ticc_pkg::TIMER_CONTROL_ADDR) begin
         ps_ff <= bus_wdata[2:0];
      end
   end

   // free prescaler, tick when low ps bits of divider all ones
   always_ff @(posedge mclk) begin
      if (rst) begin
         div_ff <= '0;
      end else begin
         div_ff <= div_ff + 1'b1;
      end
   end

   assign div_mask = ticc_pkg::DIV_WIDTH'((7'h01 << ps_ff) - 7'h01);

   always_comb begin
      if (ps_ff == ticc_pkg::PS_EXT_CLOCK) begin
         tick = rise[0];
      end else begin
         tick = (div_ff & div_mask) == div_mask;
      end
   end

   // timer counter
   always_ff @(posedge mclk) begin
      if (rst) begin
         count_ff <= '0;
      end else if (tick) begin
         count_ff <= count_ff + 1'b1;
      end
   end

   assign ovf = tick && (&count_ff);

   // edge qualification per channel
   always_comb begin
      for (int i = 0; i < NUM_CHAN; i++) begin
         case (ticc_pkg::ticc_edge_type'(ctrl_ff[i][ticc_pkg::CTL_ELSB_BIT:ticc_pkg::CTL_ELSA_BIT]))
            ticc_pkg::EDGE_RISE: cap[i] = rise[i];
            ticc_pkg::EDGE_FALL: cap[i] = fall[i];
            ticc_pkg::EDGE_ANY: cap[i] = rise[i] | fall[i];
            default: cap[i] = 1'b0;
         endcase
      end
   end

   genvar g;
   generate
      for (g = 0; g < NUM_CHAN; g++) begin : g_chan
         localparam logic [7:0] IMPL = (g % 2 == 1) ? ticc_pkg::ODD_CONTROL_MASK : ticc_pkg::EVEN_CONTROL_MASK;
         logic ctrl_wr;
         assign ctrl_wr = bus_wr && bus_addr == ticc_pkg::CHAN_CONTROL_ADDR[g];

         // control register, flag cleared by writing zero, capture wins
         always_ff @(posedge mclk) begin
            if (rst) begin
               ctrl_ff[g] <= ticc_pkg::CHAN_CONTROL_RESET;
            end else begin
               if (ctrl_wr) begin
                  ctrl_ff[g][6:0] <= bus_wdata[6:0] & IMPL[6:0];
               end
               if (cap[g]) begin
                  ctrl_ff[g][ticc_pkg::CTL_FLAG_BIT] <= 1'b1;
               end else if (ctrl_wr && !bus_wdata[ticc_pkg::CTL_FLAG_BIT]) begin
                  ctrl_ff[g][ticc_pkg::CTL_FLAG_BIT] <= 1'b0;
               end
            end
         end

         // value register, no reset so content survives it
         always_ff @(posedge mclk) begin
            if (cap[g]) begin
               value_ff[g] <= count_ff;
            end else if (bus_wr && bus_addr == ticc_pkg::CHAN_VALUE_HIGH_ADDR[g]) begin
               value_ff[g][15:8] <= bus_wdata;
            end else if (bus_wr && bus_addr == ticc_pkg::CHAN_VALUE_LOW_ADDR[g]) begin
               value_ff[g][7:0] <= bus_wdata;
            end
         end

         assign chan_req[g] = ctrl_ff[g][ticc_pkg::CTL_FLAG_BIT] & ctrl_ff[g][ticc_pkg::CTL_IE_BIT];

         property p_capture_loads;
            @(posedge mclk) disable iff (rst)
            cap[g] |=> value_ff[g] == $past(count_ff);
         endproperty
         a_capture_loads: assert property (p_capture_loads)
            else $error("capture did not latch counter");

         property p_capture_flag_set;
            @(posedge mclk) disable iff (rst)
            (cap[g] && ctrl_ff[g][ticc_pkg::CTL_FLAG_BIT]) |=>
               (value_ff[g] == $past(count_ff)) && ctrl_ff[g][ticc_pkg::CTL_FLAG_BIT];
         endproperty
         a_capture_flag_set: assert property (p_capture_flag_set)
            else $error("capture skipped while flag set");

         property p_flag_sets;
            @(posedge mclk) disable iff (rst)
            cap[g] |=> ctrl_ff[g][ticc_pkg::CTL_FLAG_BIT];
         endproperty
         a_flag_sets: assert property (p_flag_sets)
            else $error("event flag not set by capture");

         property p_rise_only;
            @(posedge mclk) disable iff (rst)
            (ctrl_ff[g][3:2] == 2'h1 && fall[g]) |-> !cap[g];
         endproperty
         a_rise_only: assert property (p_rise_only)
            else $error("falling edge captured in rising mode");

         sequence s_clean_rise;
            (ctrl_ff[g][3:2] == 2'h1 && !chan_pin[g]) ##1 (chan_pin[g] && ctrl_ff[g][3:2] == 2'h1) [*3];
         endsequence
         property p_sync_capture;
            @(posedge mclk) disable iff (rst)
            s_clean_rise and (!pin_sync_ff[g] ##1 1'b1 [*3]) |-> $past(cap[g]) || cap[g];
         endproperty
         a_sync_capture: assert property (p_sync_capture)
            else $error("synchronised rise did not capture");

         if (g % 2 == 1) begin : g_odd
            property p_odd_bit5;
               @(posedge mclk) disable iff (rst)
               !ctrl_ff[g][ticc_pkg::CTL_MSB_BIT];
            endproperty
            a_odd_bit5: assert property (p_odd_bit5)
               else $error("odd channel bit 5 set");
         end
      end
   endgenerate

   // interrupt status, read clears, set wins
   assign irq_events = {1'b0, ovf, cap};
   assign status_rd = bus_rd && bus_addr == ticc_pkg::IRQ_STATUS_ADDR;

   always_ff @(posedge mclk) begin
      if (rst) begin
         irq_status_ff <= ticc_pkg::IRQ_STATUS_RESET;
      end else if (status_rd) begin
         irq_status_ff <= irq_events;
      end else begin
         irq_status_ff <= irq_status_ff | irq_events;
      end
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         irq_mask_ff <= ticc_pkg::IRQ_MASK_RESET;
      end else if (bus_wr && bus_addr == ticc_pkg::IRQ_MASK_ADDR) begin
         irq_mask_ff <= bus_wdata & ticc_pkg::IRQ_IMPL_MASK;
      end
   end

   assign irq = (|chan_req) || (|(irq_status_ff & irq_mask_ff));

   // read mux
   always_comb begin
      nxt_rdata = ticc_pkg::READ_UNMAPPED;
      if (bus_addr == ticc_pkg::TIMER_CONTROL_ADDR) begin
         nxt_rdata = {5'h00, ps_ff};
      end else if (bus_addr == ticc_pkg::COUNT_HIGH_ADDR) begin
         nxt_rdata = count_ff[15:8];
      end else if (bus_addr == ticc_pkg::COUNT_LOW_ADDR) begin
         nxt_rdata = count_ff[7:0];
      end else if (bus_addr == ticc_pkg::IRQ_STATUS_ADDR) begin
         nxt_rdata = irq_status_ff;
      end else if (bus_addr == ticc_pkg::IRQ_MASK_ADDR) begin
         nxt_rdata = irq_mask_ff;
      end
      for (int i = 0; i < NUM_CHAN; i++) begin
         if (bus_addr == ticc_pkg::CHAN_CONTROL_ADDR[i]) begin
            nxt_rdata = ctrl_ff[i];
         end
         if (bus_addr == ticc_pkg::CHAN_VALUE_HIGH_ADDR[i]) begin
            nxt_rdata = value_ff[i][15:8];
         end
         if (bus_addr == ticc_pkg::CHAN_VALUE_LOW_ADDR[i]) begin
            nxt_rdata = value_ff[i][7:0];
         end
      end
   end

   // read data valid only in the cycle after the strobe
   always_ff @(posedge mclk) begin
      if (rst) begin
         bus_rdata_ff <= 8'h00;
      end else if (bus_rd) begin
         bus_rdata_ff <= nxt_rdata;
      end else begin
         bus_rdata_ff <= 8'h00;
      end
   end

   assign bus_rdata = bus_rdata_ff;

   property p_irq_level;
      @(posedge mclk) disable iff (rst)
      (|chan_req) |-> irq;
   endproperty
   a_irq_level: assert property (p_irq_level)
      else $error("enabled flag without interrupt");

   property p_ctrl_reset;
      @(posedge mclk)
      rst |=> ctrl_ff[0] == 8'h00 && ctrl_ff[1] == 8'h00 && ctrl_ff[4] == 8'h00;
   endproperty
   a_ctrl_reset: assert property (p_ctrl_reset)
      else $error("control not zero after reset");

   property p_div1_count;
      @(posedge mclk) disable iff (rst)
      (ps_ff == 3'h0) ##1 (ps_ff == 3'h0) |-> count_ff == $past(count_ff) + 16'h0001;
   endproperty
   a_div1_count: assert property (p_div1_count)
      else $error("divide-by-one did not count every cycle");

   sequence s_ext_idle;
      (ps_ff == 3'h7) && !rise[0];
   endsequence
   property p_ext_hold;
      @(posedge mclk) disable iff (rst)
      s_ext_idle ##1 (ps_ff == 3'h7) |-> count_ff == $past(count_ff);
   endproperty
   a_ext_hold: assert property (p_ext_hold)
      else $error("counter moved without external edge");

   property p_value_hold_reset;
      @(posedge mclk)
      (rst && !$past(rst)) |=> value_ff[2] == $past(value_ff[2]);
   endproperty
   a_value_hold_reset: assert property (p_value_hold_reset)
      else $error("reset changed capture value");
endmodule : ticc_capture
`default_nettype wire

// ---- sim/ticc_pin_src.sv ----
// signal source model for the six channel input pins
// assumes the bench names the wanted pin levels; the pins follow them after a rising edge
`timescale 1ns/1ps
`default_nettype none
module ticc_pin_src (
   input wire logic mclk,
   input wire logic [ticc_pkg::NUM_CHAN-1:0] pin_want,
   output logic [ticc_pkg::NUM_CHAN-1:0] chan_pin
);
   initial chan_pin = '0;
   // a level stands for at least one whole clock, so no edge is too short to see
   always @(posedge mclk) chan_pin <= pin_want;
endmodule : ticc_pin_src
`default_nettype wire

// ---- sim/ticc_capture_tb_top.sv ----
// self-checking bench for the timer input-capture block
// assumes the pin source model and the register port as handed over
`timescale 1ns/1ps
`default_nettype none
module ticc_capture_tb_top;
   typedef struct {logic [15:0] exp; logic [1:0] kind;} ticc_note_type;
   logic mclk, rst, bus_wr, bus_rd, irq, rd_q;
   logic [15:0] bus_addr, hb_prev, v;
   logic [7:0] bus_wdata, bus_rdata, hb;
   logic [5:0] pin_want, chan_pin;
   int miscompares, n_compared, ch, m, ps;
   ticc_note_type notes[$];
   ticc_note_type nt;
   ticc_capture DUT (.mclk(mclk), .rst(rst), .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_wr(bus_wr),
      .bus_rd(bus_rd), .bus_rdata(bus_rdata), .chan_pin(chan_pin), .irq(irq));
   ticc_pin_src SRC (.mclk(mclk), .pin_want(pin_want), .chan_pin(chan_pin));
   always #20 mclk = ~mclk;
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      n_compared++;
      if (seen !== exp) begin
         miscompares++;
         $display("FAIL at %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : chk
   task automatic end_sim;
      $display("compared %0d, mismatched %0d", n_compared, miscompares);
      if (miscompares == 0 && n_compared > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask : end_sim
   task automatic wt(input int n);
      repeat (n) @(posedge mclk);
   endtask : wt
   task automatic wr(input logic [15:0] a, input logic [7:0] d);
      @(posedge mclk);
      bus_wr <= 1'b1;
      bus_addr <= a;
      bus_wdata <= d;
      @(posedge mclk);
      bus_wr <= 1'b0;
   endtask : wr
   // kind 0 byte, 1 high half, 2 low half as base, 3 low half checked as distance from base
   task automatic rd(input logic [15:0] a, input logic [15:0] e, input logic [1:0] k);
      @(posedge mclk);
      bus_rd <= 1'b1;
      bus_addr <= a;
      notes.push_back('{e, k});
      @(posedge mclk);
      bus_rd <= 1'b0;
   endtask : rd
   task automatic rd16(input int c, input logic [15:0] e, input logic [1:0] k);
      rd(ticc_pkg::CHAN_VALUE_HIGH_ADDR[c], 16'h0000, 2'h1);
      rd(ticc_pkg::CHAN_VALUE_LOW_ADDR[c], e, k);
   endtask : rd16
   task automatic pin(input int c, input logic lvl);
      @(posedge mclk);
      pin_want[c] <= lvl;
   endtask : pin
   // read results stand in the cycle after the strobe only
   always @(posedge mclk) begin
      if (rd_q) begin
         nt = notes.pop_front();
         case (nt.kind)
            2'h0: chk({8'h00, bus_rdata}, nt.exp);
            2'h1: hb = bus_rdata;
            2'h2: hb_prev = {hb, bus_rdata};
            default: chk({hb, bus_rdata} - hb_prev, nt.exp);
         endcase
      end
      rd_q = bus_rd;
   end
   initial begin
      wt(100000);
      miscompares++;
      end_sim();
   end
   initial begin
      mclk = 1'b0;
      rst = 1'b1;
      bus_wr = 1'b0;
      bus_rd = 1'b0;
      bus_addr = 16'h0000;
      bus_wdata = 8'h00;
      pin_want = '0;
      rd_q = 1'b0;
      void'($urandom(90));
      wt(6);
      rst <= 1'b0;
      for (ch = 0; ch < 6; ch++) begin
         rd(ticc_pkg::CHAN_CONTROL_ADDR[ch], 16'h0000, 2'h0);
         wr(ticc_pkg::CHAN_CONTROL_ADDR[ch], 8'hFF);
         rd(ticc_pkg::CHAN_CONTROL_ADDR[ch], 16'(8'h7F & (ch % 2 ? ticc_pkg::ODD_CONTROL_MASK :
            ticc_pkg::EVEN_CONTROL_MASK)), 2'h0);
         wr(ticc_pkg::CHAN_CONTROL_ADDR[ch], 8'h00);
         v = 16'($urandom);
         wr(ticc_pkg::CHAN_VALUE_HIGH_ADDR[ch], v[15:8]);
         wr(ticc_pkg::CHAN_VALUE_LOW_ADDR[ch], v[7:0]);
         rd(ticc_pkg::CHAN_VALUE_HIGH_ADDR[ch], {8'h00, v[15:8]}, 2'h0);
         rd(ticc_pkg::CHAN_VALUE_LOW_ADDR[ch], {8'h00, v[7:0]}, 2'h0);
      end
      rd(16'h0500, {8'h00, ticc_pkg::READ_UNMAPPED}, 2'h0);
      wr(16'h0500, 8'h5A);
      rd(16'h0500, {8'h00, ticc_pkg::READ_UNMAPPED}, 2'h0);
      // second reset mid-run: values of the last channel written must survive
      @(posedge mclk);
      rst <= 1'b1;
      wt(3);
      rst <= 1'b0;
      rd(ticc_pkg::CHAN_VALUE_HIGH_ADDR[5], {8'h00, v[15:8]}, 2'h0);
      rd(ticc_pkg::CHAN_VALUE_LOW_ADDR[5], {8'h00, v[7:0]}, 2'h0);
      $display("test registers done");
      for (ch = 0; ch < 6; ch++) begin
         for (m = 0; m < 4; m++) begin
            wr(ticc_pkg::CHAN_CONTROL_ADDR[ch], 8'(m << 2));
            pin(ch, 1'b1);
            wt(6);
            rd(ticc_pkg::CHAN_CONTROL_ADDR[ch], (m % 2 ? 16'h80 : 16'h00) | 16'(m << 2), 2'h0);
            wr(ticc_pkg::CHAN_CONTROL_ADDR[ch], 8'(m << 2));
            pin(ch, 1'b0);
            wt(6);
            rd(ticc_pkg::CHAN_CONTROL_ADDR[ch], (m > 1 ? 16'h80 : 16'h00) | 16'(m << 2), 2'h0);
            wr(ticc_pkg::CHAN_CONTROL_ADDR[ch], 8'h00);
         end
      end
      rd(ticc_pkg::IRQ_STATUS_ADDR, 16'h003F, 2'h0);
      rd(ticc_pkg::IRQ_STATUS_ADDR, 16'h0000, 2'h0);
      $display("test edges done");
      wr(ticc_pkg::CHAN_CONTROL_ADDR[2], 8'h44);
      pin(2, 1'b1);
      wt(6);
      chk({15'h0, irq}, 16'h0001);
      wr(ticc_pkg::CHAN_CONTROL_ADDR[2], 8'h44);
      wt(2);
      chk({15'h0, irq}, 16'h0000);
      rd(ticc_pkg::IRQ_STATUS_ADDR, 16'h0004, 2'h0);
      pin(2, 1'b0);
      wr(ticc_pkg::IRQ_MASK_ADDR, 8'h08);
      wr(ticc_pkg::CHAN_CONTROL_ADDR[3], 8'h04);
      pin(3, 1'b1);
      wt(6);
      chk({15'h0, irq}, 16'h0001);
      rd(ticc_pkg::IRQ_MASK_ADDR, 16'h0008, 2'h0);
      rd(ticc_pkg::IRQ_STATUS_ADDR, 16'h0008, 2'h0);
      wt(2);
      chk({15'h0, irq}, 16'h0000);
      wr(ticc_pkg::IRQ_MASK_ADDR, 8'h00);
      wr(ticc_pkg::CHAN_CONTROL_ADDR[2], 8'h00);
      wr(ticc_pkg::CHAN_CONTROL_ADDR[3], 8'h00);
      pin(3, 1'b0);
      $display("test interrupts done");
      // rising edges 16 << ps cycles apart must capture counts 16 apart; flag left set
      for (ps = 0; ps < 7; ps++) begin
         ch = ps % 6;
         wr(ticc_pkg::TIMER_CONTROL_ADDR, 8'(ps));
         rd(ticc_pkg::TIMER_CONTROL_ADDR, 16'(ps), 2'h0);
         wr(ticc_pkg::CHAN_CONTROL_ADDR[ch], 8'h04);
         pin(ch, 1'b1);
         wt(6);
         rd16(ch, 16'h0000, 2'h2);
         pin(ch, 1'b0);
         wt((16 << ps) - 12);
         pin(ch, 1'b1);
         wt(6);
         rd16(ch, 16'h0010, 2'h3);
         pin(ch, 1'b0);
         wr(ticc_pkg::CHAN_CONTROL_ADDR[ch], 8'h00);
      end
      wr(ticc_pkg::TIMER_CONTROL_ADDR, {5'h00, ticc_pkg::PS_EXT_CLOCK});
      wr(ticc_pkg::CHAN_CONTROL_ADDR[1], 8'h04);
      pin(1, 1'b1);
      wt(6);
      rd16(1, 16'h0000, 2'h2);
      pin(1, 1'b0);
      for (m = 0; m < 5; m++) begin
         pin(0, 1'b1);
         wt(2);
         pin(0, 1'b0);
         wt(2);
      end
      pin(1, 1'b1);
      wt(6);
      rd16(1, 16'h0005, 2'h3);
      // every channel captured since the last clear; then one full wrap must flag overflow
      rd(ticc_pkg::IRQ_STATUS_ADDR, 16'h003F, 2'h0);
      wr(ticc_pkg::TIMER_CONTROL_ADDR, 8'h00);
      wr(ticc_pkg::IRQ_MASK_ADDR, 8'h40);
      wt(65540);
      chk({15'h0, irq}, 16'h0001);
      rd(ticc_pkg::IRQ_STATUS_ADDR, 16'h0040, 2'h0);
      $display("test counter clock done");
      wt(4);
      chk(16'(notes.size()), 16'h0000);
      end_sim();
   end
endmodule : ticc_capture_tb_top
`default_nettype wire
